// [ccr_pkg.sv]
// Functional notes
// - fast-charge current: 512 mA plus 64 mA steps
// - bit 1 picks boost cold threshold, default low
// - bit 0 forces 20% fast, 50% pre-charge
// - pre-charge current: 128 mA plus 128 mA steps
// - termination current same scale, both default 0001
// - current registers reset to 0x20 and 0x11
// - voltage register resets 0xB2, three fields
// - every field reads back last written value
// - charge voltage: 3.504 V plus 16 mV steps
// - low-battery select: 0 is 2.8 V, 1 is 3.0 V
// - serial target address 0x6B, registers read/write
`default_nettype none
package ccr_pkg;

   // ----------------------------------------------------------------
   // serial target and register map
   // ----------------------------------------------------------------
   localparam logic [6:0] CCR_DEV_ADDR = 7'h6B;
   localparam logic [7:0] CCR_OFS_CUR = 8'h02;
   localparam logic [7:0] CCR_OFS_PRE = 8'h03;
   localparam logic [7:0] CCR_OFS_VOLT = 8'h04;
   localparam logic [7:0] CCR_RST_CUR = 8'h20;
   localparam logic [7:0] CCR_RST_PRE = 8'h11;
   localparam logic [7:0] CCR_RST_VOLT = 8'hB2;
   localparam logic [7:0] CCR_UNMAPPED_READ = 8'h00;
   localparam logic [3:0] CCR_BITS_PER_BYTE = 4'h8;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CCR_FCC_MSB = 7;
   localparam int CCR_FCC_LSB = 2;
   localparam int CCR_COLD_BIT = 1;
   localparam int CCR_FORCE_BIT = 0;
   localparam int CCR_PRE_MSB = 7;
   localparam int CCR_PRE_LSB = 4;
   localparam int CCR_TERM_MSB = 3;
   localparam int CCR_TERM_LSB = 0;
   localparam int CCR_VOLT_MSB = 7;
   localparam int CCR_VOLT_LSB = 2;
   localparam int CCR_BATLOW_BIT = 1;
   localparam int CCR_RECHG_BIT = 0;

   // ----------------------------------------------------------------
   // code scaling
   // ----------------------------------------------------------------
   localparam logic [12:0] CCR_FCC_OFS_MA = 13'h0200;
   localparam logic [12:0] CCR_FCC_STEP_MA = 13'h0040;
   localparam logic [12:0] CCR_FCC_FORCE_DIV = 13'h0005;
   localparam logic [11:0] CCR_PRE_OFS_MA = 12'h080;
   localparam logic [11:0] CCR_PRE_STEP_MA = 12'h080;
   localparam logic [11:0] CCR_PRE_FORCE_DIV = 12'h002;
   localparam logic [12:0] CCR_VOLT_OFS_MV = 13'h0DB0;
   localparam logic [12:0] CCR_VOLT_STEP_MV = 13'h0010;
   localparam logic [11:0] CCR_BATLOW_LO_MV = 12'hAF0;
   localparam logic [11:0] CCR_BATLOW_HI_MV = 12'hBB8;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      CCR_ST_IDLE = 7'h01,
      CCR_ST_ADDR = 7'h02,
      CCR_ST_ACK = 7'h04,
      CCR_ST_REGA = 7'h08,
      CCR_ST_WDATA = 7'h10,
      CCR_ST_RDATA = 7'h20,
      CCR_ST_RACK = 7'h40
   } ccr_state_type;

   typedef struct packed {
      logic [12:0] fast_charge_ma;
      logic [11:0] precharge_ma;
      logic [11:0] termination_ma;
      logic [12:0] charge_voltage_mv;
      logic [11:0] low_battery_mv;
      logic boost_cold_high;
      logic recharge_threshold_select;
   } ccr_setting_type;

   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic scl_f;
      logic sda_f;
      ccr_state_type st;
      ccr_state_type ack_next;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic [7:0] ptr;
      logic ack_ok;
      logic drive;
      logic [7:0] charge_current_control;
      logic [7:0] precharge_termination_control;
      logic [7:0] charge_voltage_control;
      ccr_setting_type set;
   } ccr_regs_type;

endpackage : ccr_pkg
`default_nettype wire

// [ccr_charge_regs.sv]
`timescale 1ns/1ns
`default_nettype none
module ccr_charge_regs import ccr_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // serial register port, data line open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // decoded settings
   output ccr_setting_type setting_o
);

   ccr_regs_type r;
   ccr_regs_type next_r;
   logic scl_ok;
   logic sda_ok;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic [7:0] rd_now;
   logic [7:0] rd_inc;
   logic seen_clk;

   // ----------------------------------------------------------------
   // line events from the filtered levels
   // ----------------------------------------------------------------
   assign scl_ok = r.scl_s[2] == r.scl_s[1];
   assign sda_ok = r.sda_s[2] == r.sda_s[1];
   assign scl_rise = scl_ok && r.scl_s[2] && !r.scl_f;
   assign scl_fall = scl_ok && !r.scl_s[2] && r.scl_f;
   assign start_cond = r.scl_f && !scl_fall && sda_ok && !r.sda_s[2] && r.sda_f;
   assign stop_cond = r.scl_f && !scl_fall && sda_ok && r.sda_s[2] && !r.sda_f;

   function automatic logic [7:0] read_byte(input ccr_regs_type s, input logic [7:0] a);
      logic [7:0] d;
      d = CCR_UNMAPPED_READ;
      case (a)
         CCR_OFS_CUR: d = s.charge_current_control;
         CCR_OFS_PRE: d = s.precharge_termination_control;
         CCR_OFS_VOLT: d = s.charge_voltage_control;
         default: d = CCR_UNMAPPED_READ;
      endcase
      return d;
   endfunction : read_byte

   assign rd_now = read_byte(r, r.ptr);
   assign rd_inc = read_byte(r, r.ptr + 8'h01);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.scl_s = {r.scl_s[1:0], scl_i};
      next_r.sda_s = {r.sda_s[1:0], sda_i};
      if (scl_ok) begin
         next_r.scl_f = r.scl_s[2];
      end
      if (sda_ok) begin
         next_r.sda_f = r.sda_s[2];
      end
      if (start_cond) begin
         next_r.st = CCR_ST_ADDR;
         next_r.cnt = 4'h0;
         next_r.drive = 1'b0;
      end else if (stop_cond) begin
         next_r.st = CCR_ST_IDLE;
         next_r.drive = 1'b0;
      end else if (scl_rise) begin
         case (r.st)
            CCR_ST_ADDR, CCR_ST_REGA, CCR_ST_WDATA: begin
               next_r.shift = {r.shift[6:0], r.sda_f};
               next_r.cnt = r.cnt + 4'h1;
            end
            CCR_ST_RDATA: begin
               next_r.cnt = r.cnt + 4'h1;
            end
            CCR_ST_RACK: begin
               next_r.ack_ok = !r.sda_f;
            end
            default: begin
               next_r.cnt = r.cnt;
            end
         endcase
      end else if (scl_fall) begin
         case (r.st)
            CCR_ST_ADDR: begin
               if (r.cnt == CCR_BITS_PER_BYTE) begin
                  if (r.shift[7:1] == CCR_DEV_ADDR) begin
                     next_r.st = CCR_ST_ACK;
                     next_r.drive = 1'b1;
                     next_r.ack_next = r.shift[0] ? CCR_ST_RDATA : CCR_ST_REGA;
                  end else begin
                     next_r.st = CCR_ST_IDLE;
                  end
               end
            end
            CCR_ST_REGA: begin
               if (r.cnt == CCR_BITS_PER_BYTE) begin
                  next_r.ptr = r.shift;
                  next_r.st = CCR_ST_ACK;
                  next_r.drive = 1'b1;
                  next_r.ack_next = CCR_ST_WDATA;
               end
            end
            CCR_ST_WDATA: begin
               if (r.cnt == CCR_BITS_PER_BYTE) begin
                  // unmapped offsets are acknowledged and dropped
                  case (r.ptr)
                     CCR_OFS_CUR: next_r.charge_current_control = r.shift;
                     CCR_OFS_PRE: next_r.precharge_termination_control = r.shift;
                     CCR_OFS_VOLT: next_r.charge_voltage_control = r.shift;
                     default: next_r.ptr = r.ptr;
                  endcase
                  next_r.ptr = r.ptr + 8'h01;
                  next_r.st = CCR_ST_ACK;
                  next_r.drive = 1'b1;
                  next_r.ack_next = CCR_ST_WDATA;
               end
            end
            CCR_ST_ACK: begin
               next_r.cnt = 4'h0;
               next_r.st = r.ack_next;
               next_r.drive = 1'b0;
               if (r.ack_next == CCR_ST_RDATA) begin
                  next_r.shift = rd_now;
                  next_r.drive = !rd_now[7];
               end
            end
            CCR_ST_RDATA: begin
               if (r.cnt == CCR_BITS_PER_BYTE) begin
                  next_r.st = CCR_ST_RACK;
                  next_r.drive = 1'b0;
               end else begin
                  next_r.shift = {r.shift[6:0], 1'b0};
                  next_r.drive = !r.shift[6];
               end
            end
            CCR_ST_RACK: begin
               if (r.ack_ok) begin
                  next_r.ptr = r.ptr + 8'h01;
                  next_r.shift = rd_inc;
                  next_r.drive = !rd_inc[7];
                  next_r.cnt = 4'h0;
                  next_r.st = CCR_ST_RDATA;
               end else begin
                  next_r.st = CCR_ST_IDLE;
               end
            end
            default: begin
               next_r.st = CCR_ST_IDLE;
            end
         endcase
      end
      // decoded settings follow the stored registers one cycle later
      next_r.set.fast_charge_ma = CCR_FCC_OFS_MA + CCR_FCC_STEP_MA *
         {7'h00, r.charge_current_control[CCR_FCC_MSB:CCR_FCC_LSB]};
      next_r.set.precharge_ma = CCR_PRE_OFS_MA + CCR_PRE_STEP_MA *
         {8'h00, r.precharge_termination_control[CCR_PRE_MSB:CCR_PRE_LSB]};
      if (r.charge_current_control[CCR_FORCE_BIT]) begin
         next_r.set.fast_charge_ma = next_r.set.fast_charge_ma / CCR_FCC_FORCE_DIV;
         next_r.set.precharge_ma = next_r.set.precharge_ma / CCR_PRE_FORCE_DIV;
      end
      next_r.set.termination_ma = CCR_PRE_OFS_MA + CCR_PRE_STEP_MA *
         {8'h00, r.precharge_termination_control[CCR_TERM_MSB:CCR_TERM_LSB]};
      next_r.set.charge_voltage_mv = CCR_VOLT_OFS_MV + CCR_VOLT_STEP_MV *
         {7'h00, r.charge_voltage_control[CCR_VOLT_MSB:CCR_VOLT_LSB]};
      next_r.set.low_battery_mv = r.charge_voltage_control[CCR_BATLOW_BIT] ?
         CCR_BATLOW_HI_MV : CCR_BATLOW_LO_MV;
      next_r.set.boost_cold_high = r.charge_current_control[CCR_COLD_BIT];
      next_r.set.recharge_threshold_select = r.charge_voltage_control[CCR_RECHG_BIT];
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         r <= '0;
         r.scl_s <= 3'h7;
         r.sda_s <= 3'h7;
         r.scl_f <= 1'b1;
         r.sda_f <= 1'b1;
         r.st <= CCR_ST_IDLE;
         r.ack_next <= CCR_ST_IDLE;
         r.charge_current_control <= CCR_RST_CUR;
         r.precharge_termination_control <= CCR_RST_PRE;
         r.charge_voltage_control <= CCR_RST_VOLT;
      end else begin
         r <= next_r;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         seen_clk <= 1'b0;
      end else begin
         seen_clk <= 1'b1;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = r.drive;
   assign setting_o = r.set;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_fast_scale;
      @(posedge clk_i) disable iff (!nrst_i)
      !r.charge_current_control[CCR_FORCE_BIT]
      |=> setting_o.fast_charge_ma == 13'h0200 + 13'h0040 *
          {7'h00, $past(r.charge_current_control[7:2])};
   endproperty
   a_fast_scale: assert property (p_fast_scale) else $error("fast current scale wrong");

   property p_forced;
      @(posedge clk_i) disable iff (!nrst_i)
      (r.charge_current_control[0] && r.precharge_termination_control[7:4] == 4'h3)
      |=> setting_o.precharge_ma == 12'h100;
   endproperty
   a_forced: assert property (p_forced) else $error("forced pre-charge not halved");

   property p_cold;
      @(posedge clk_i) disable iff (!nrst_i)
      $changed(r.charge_current_control[1]) |=> setting_o.boost_cold_high == $past(r.charge_current_control[1]);
   endproperty
   a_cold: assert property (p_cold) else $error("cold select not followed");

   property p_term;
      @(posedge clk_i) disable iff (!nrst_i)
      r.precharge_termination_control[3:0] == 4'hF [*2] |-> setting_o.termination_ma == 12'h800;
   endproperty
   a_term: assert property (p_term) else $error("termination scale wrong");

   property p_pre;
      @(posedge clk_i) disable iff (!nrst_i)
      (!r.charge_current_control[0] && r.precharge_termination_control[7:4] == 4'h1) [*2]
      |-> setting_o.precharge_ma == 12'h100;
   endproperty
   a_pre: assert property (p_pre) else $error("pre-charge scale wrong");

   property p_reset_vals;
      @(posedge clk_i) disable iff (!nrst_i)
      !seen_clk |-> r.charge_current_control == 8'h20 && r.precharge_termination_control == 8'h11;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("current reset value wrong");

   property p_volt_reset;
      @(posedge clk_i) disable iff (!nrst_i)
      !seen_clk |-> r.charge_voltage_control == 8'hB2 ##1 setting_o.charge_voltage_mv == 13'h1070;
   endproperty
   a_volt_reset: assert property (p_volt_reset) else $error("voltage reset wrong");

   property p_write;
      @(posedge clk_i) disable iff (!nrst_i)
      (scl_fall && !start_cond && !stop_cond && r.st == CCR_ST_WDATA && r.cnt == 4'h8 &&
       r.ptr == 8'h04) |=> r.charge_voltage_control == $past(r.shift) && sda_oe_o;
   endproperty
   a_write: assert property (p_write) else $error("write not stored");

   property p_volt;
      @(posedge clk_i) disable iff (!nrst_i)
      r.charge_voltage_control[7:2] == 6'h3F [*2] |-> setting_o.charge_voltage_mv == 13'h11A0;
   endproperty
   a_volt: assert property (p_volt) else $error("voltage scale wrong");

   property p_batlow;
      @(posedge clk_i) disable iff (!nrst_i)
      !r.charge_voltage_control[1] [*2] |-> setting_o.low_battery_mv == 12'hAF0;
   endproperty
   a_batlow: assert property (p_batlow) else $error("low-battery level wrong");

   property p_addr;
      @(posedge clk_i) disable iff (!nrst_i)
      (scl_fall && !start_cond && !stop_cond && r.st == CCR_ST_ADDR && r.cnt == 4'h8 &&
       r.shift[7:1] != 7'h6B) |=> !sda_oe_o && r.st == CCR_ST_IDLE;
   endproperty
   a_addr: assert property (p_addr) else $error("foreign address answered");

endmodule : ccr_charge_regs
`default_nettype wire

// [ccr_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ccr_host_model (
   // clock
   input wire logic clk_i,
   // serial bus, data line open drain
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   // ----------------------------------------------------------------
   // bus phases: each change is six clocks after the last one, except that in a data bit SCL falls twelve clocks after it rises
   // ----------------------------------------------------------------
   localparam int Q = 6;

   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end

   task automatic step(input logic c, input logic d);
      repeat (Q) @(posedge clk_i);
      scl_o <= c;
      sda_oe_o <= !d;
   endtask : step

   task automatic bit_x(input logic b, output logic r);
      step(1'b0, b);
      step(1'b1, b);
      repeat (Q) @(posedge clk_i);
      // look at the line mid-cycle, clear of the edge that moves the device's drive
      @(negedge clk_i);
      r = sda_i;
      step(1'b0, b);
   endtask : bit_x

   task automatic byte_x(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                         output logic ao);
      for (int i = 7; i >= 0; i--) begin
         bit_x(tx[i], rx[i]);
      end
      bit_x(ai, ao);
   endtask : byte_x

   task automatic start;
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask : start

   task automatic stop;
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask : stop

   // ----------------------------------------------------------------
   // register transfers, pointer then data bytes
   // ----------------------------------------------------------------
   task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d [$],
                     output logic nack);
      logic [7:0] rx;
      logic a;
      start();
      byte_x({dev, 1'b0}, 1'b1, rx, nack);
      byte_x(ofs, 1'b1, rx, a);
      nack = nack | a;
      foreach (d[i]) begin
         byte_x(d[i], 1'b1, rx, a);
         nack = nack | a;
      end
      stop();
   endtask : wr

   task automatic rd(input logic [7:0] ofs, input int n, output logic [7:0] q [$]);
      logic [7:0] rx;
      logic a;
      q = {};
      start();
      byte_x({7'h6B, 1'b0}, 1'b1, rx, a);
      byte_x(ofs, 1'b1, rx, a);
      start();
      byte_x({7'h6B, 1'b1}, 1'b1, rx, a);
      for (int i = 0; i < n; i++) begin
         byte_x(8'hFF, (i == n - 1), rx, a);
         q.push_back(rx);
      end
      stop();
   endtask : rd
endmodule : ccr_host_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench import ccr_pkg::*;;
   logic clk;
   logic nrst;
   logic scl;
   logic host_oe;
   logic dut_sda;
   logic dut_oe;
   wire logic sda;
   ccr_setting_type setting;
   int bad_count;
   int checks_done;
   logic [7:0] q [$];
   logic [7:0] d [$];
   logic nack;

   // open-drain wire with pull-up
   assign sda = !host_oe && (!dut_oe || dut_sda);

   ccr_charge_regs dut (.clk_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda),
      .sda_o(dut_sda), .sda_oe_o(dut_oe), .setting_o(setting));
   ccr_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // expectations and comparisons
   // ----------------------------------------------------------------
   function automatic ccr_setting_type exp_set(input logic [7:0] c, p, v);
      ccr_setting_type s;
      s.fast_charge_ma = (13'h200 + 13'h40 * c[7:2]) / (c[0] ? 13'h5 : 13'h1);
      s.precharge_ma = (12'h80 + 12'h80 * p[7:4]) / (c[0] ? 12'h2 : 12'h1);
      s.termination_ma = 12'h80 + 12'h80 * p[3:0];
      s.charge_voltage_mv = 13'hDB0 + 13'h10 * v[7:2];
      s.low_battery_mv = v[1] ? 12'hBB8 : 12'hAF0;
      s.boost_cold_high = c[1];
      s.recharge_threshold_select = v[0];
      return s;
   endfunction : exp_set

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_byte

   task automatic check_set(input ccr_setting_type exp);
      checks_done++;
      if (setting !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, setting, exp);
      end
   endtask : check_set

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic test_reset;
      @(posedge clk);
      nrst <= 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      check_set(exp_set(8'h20, 8'h11, 8'hB2));
      host.rd(8'h02, 3, q);
      check_byte(q[0], 8'h20);
      check_byte(q[1], 8'h11);
      check_byte(q[2], 8'hB2);
      $display("test_reset done at %0t", $time);
   endtask : test_reset

   task automatic test_fields;
      // third row forces reduced current with pre-charge code 3
      logic [7:0] t [4][3] = '{'{8'h9F, 8'hF0, 8'hFE}, '{8'h00, 8'h0F, 8'h01},
                               '{8'h9D, 8'h3A, 8'h55}, '{8'h42, 8'hA5, 8'hAA}};
      foreach (t[i]) begin
         d = {t[i][0], t[i][1], t[i][2]};
         host.wr(7'h6B, 8'h02, d, nack);
         check_byte({7'h00, nack}, 8'h00);
         check_set(exp_set(t[i][0], t[i][1], t[i][2]));
         host.rd(8'h02, 3, q);
         foreach (q[j]) begin
            check_byte(q[j], t[i][j]);
         end
      end
      $display("test_fields done at %0t", $time);
   endtask : test_fields

   task automatic test_bad_addr;
      d = {8'h55};
      host.wr(7'h6A, 8'h02, d, nack);
      check_byte({7'h00, nack}, 8'h01);
      host.rd(8'h02, 1, q);
      check_byte(q[0], 8'h42);
      $display("test_bad_addr done at %0t", $time);
   endtask : test_bad_addr

   task automatic test_unmapped;
      d = {8'hAA, 8'h24};
      host.wr(7'h6B, 8'h01, d, nack);
      check_byte({7'h00, nack}, 8'h00);
      check_set(exp_set(8'h24, 8'hA5, 8'hAA));
      host.rd(8'h01, 2, q);
      check_byte(q[0], 8'h00);
      check_byte(q[1], 8'h24);
      host.rd(8'h05, 1, q);
      check_byte(q[0], 8'h00);
      $display("test_unmapped done at %0t", $time);
   endtask : test_unmapped

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict

   initial begin
      nrst = 1'b0;
      bad_count = 0;
      checks_done = 0;
      test_reset();
      test_fields();
      test_bad_addr();
      test_unmapped();
      test_reset();
      print_verdict();
   end

   // the whole run needs some 20000 clocks; allow three times that
   initial begin
      #(60000 * 100);
      bad_count++;
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
